/* File: verilog/gtcc_pkg.sv */
// Shared constants of the gated 16-bit timer/counter core
package gtcc_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] OFS_CNT_LO = 8'h00;
    localparam logic [7:0] OFS_CNT_HI = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_GATE = 8'h0C;
    localparam logic [7:0] OFS_CSEL = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    localparam logic [7:0] OFS_IEN = 8'h18;
    localparam logic [7:0] OFS_ICLR = 8'h1C;

    // Field positions of counter_control_reg
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_NOSYNC_BIT = 2;
    localparam int CTRL_PS_LSB = 4;

    // Field positions of gate_control_reg
    localparam int GATE_EN_BIT = 7;
    localparam int GATE_POL_BIT = 6;
    localparam int GATE_VAL_BIT = 2;

    // Field position of the overflow event in status, enable and clear
    localparam int IRQ_OVF_BIT = 0;

    // Codes of count_clock_select; code 3 selects nothing
    localparam logic [1:0] CSEL_INSTR = 2'h0;
    localparam logic [1:0] CSEL_FOSC = 2'h1;
    localparam logic [1:0] CSEL_EXT = 2'h2;

    // Reset values and the count maximum
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [1:0] PS_RST = 2'h0;
    localparam logic [1:0] CSEL_RST = 2'h0;

    // Oscillator clocks per instruction cycle
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] PHASE_LAST = 2'(INSTR_DIV - 1);

endpackage

/* File: verilog/gtcc_ext_edge.sv */
// External count input conditioner: optional synchroniser and armed rise detect
`timescale 1ns/100ps
module gtcc_ext_edge
    import gtcc_pkg::*;
(
    input wire logic pclk,         // Core clock
    input wire logic presetn,      // Asynchronous reset, active low
    input wire logic ext_in,       // external_count_input level
    input wire logic bypass_sync,  // High: take the input unsynchronised
    input wire logic rearm,        // Forget any seen falling edge
    output logic rise              // Armed rising edge, one cycle
);

    typedef struct packed {
        logic meta;
        logic stage;
        logic prev;
        logic armed;
    } gtcc_edge_t;

    gtcc_edge_t s_reg;
    gtcc_edge_t s_next;
    logic level;

    // Next state and edge decode
    always_comb begin
        s_next = s_reg;
        s_next.meta = ext_in;
        s_next.stage = s_reg.meta;
        level = bypass_sync ? ext_in : s_reg.stage;
        s_next.prev = level;
        if (rearm) begin
            s_next.armed = 1'b0;
        end else if (s_reg.prev && !level) begin
            s_next.armed = 1'b1;
        end
        rise = s_reg.armed && !s_reg.prev && level && !rearm;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A rise only after a falling edge since the last rearm
    rise_armed_a: assert property (rise |-> !$past(rearm))
        else $error("rise counted without prior falling edge");

    // Synchronised rise reflects the pin two edges back
    sync_delay_a: assert property (
        (rise && !bypass_sync && $past(!bypass_sync)) |-> ($past(ext_in, 2) && !$past(ext_in, 3)))
        else $error("synchronised rise does not match delayed input");

endmodule

/* File: verilog/gtcc_core.sv */
// Gated 16-bit timer/counter core with APB registers and overflow interrupt
// Behaviour
// - 16-bit counter, byte writes update it directly
// - internal source times, external source counts edges
// - on and gate enable decide counting
// - clock-select register picks the only count source
// - oscillator source adds four per instruction cycle
// - asynchronous gate sources may feed the gate
// - external input counts rising edges, sync selectable
// - count a rise only after a fall
// - prescaler divides by 1, 2, 4 or 8
// - prescaler hidden, cleared by count byte writes
// - sync bit set bypasses input synchroniser
// - asynchronous external counting continues in sleep
// - mode switch may lose or add one
// - wrap all-ones to zero, set overflow flag
// - gated mode counts only at matching level
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module gtcc_core
    import gtcc_pkg::*;
(
    input wire logic pclk,          // Core oscillator clock, 10 MHz
    input wire logic presetn,       // Asynchronous reset, active low
    input wire logic psel,          // APB select
    input wire logic penable,       // APB access phase
    input wire logic pwrite,        // APB write
    input wire logic [7:0] paddr,   // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata,     // APB read data
    output logic pready,            // APB ready
    output logic pslverr,           // APB error on unmapped address
    input wire logic ext_in,        // external_count_input pin
    input wire logic gate_in,       // Gate signal, possibly asynchronous
    input wire logic sleep,         // Core in sleep, internal clocks stopped
    output logic irq                // Interrupt level
);

    typedef struct packed {
        logic [15:0] cnt;
        logic [2:0] psc;
        logic [1:0] phase;
        logic ext_pend;
        logic on;
        logic nosync;
        logic [1:0] ps;
        logic gen;
        logic gate_polarity;
        logic [1:0] csel;
        logic ovf;
        logic ien;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } gtcc_state_t;

    gtcc_state_t s_reg;
    gtcc_state_t s_next;

    logic setup;
    logic wr;
    logic cnt_wr;
    logic ext_rise;
    logic instr_tick;
    logic src_tick;
    logic gate_ok;
    logic run;
    logic adv;
    logic ovf_set;
    logic [2:0] ps_mask;
    logic [31:0] rd;
    logic mapped;

    // prescale select to mask of prescaler bits
    function automatic logic [2:0] ps_to_mask(input logic [1:0] ps);
        logic [2:0] m;
        case (ps)
            2'h0: m = 3'h0;
            2'h1: m = 3'h1;
            2'h2: m = 3'h3;
            default: m = 3'h7;
        endcase
        return m;
    endfunction

    // Counting stops and edge arming is lost while off or after a count write
    gtcc_ext_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .ext_in(ext_in),
        .bypass_sync(s_reg.nosync),
        .rearm(cnt_wr || !s_reg.on),
        .rise(ext_rise)
    );

    // Bus decode: a write lands only in the access cycle with pready high
    always_comb begin
        setup = psel && !penable;
        wr = psel && penable && s_reg.pready && pwrite;
        // either count byte write resets the prescaler
        cnt_wr = wr && ((paddr == OFS_CNT_LO) || (paddr == OFS_CNT_HI));
    end

    // Count source, gate and advance decision
    always_comb begin
        instr_tick = !sleep && (s_reg.phase == PHASE_LAST);
        // only the selected source drives the prescaler
        case (s_reg.csel)
            // timer mode, one count per instruction cycle
            CSEL_INSTR: src_tick = instr_tick;
            // every oscillator clock, four per instruction cycle
            CSEL_FOSC: src_tick = !sleep;
            // external rising edges, held for the instruction tick if synced
            CSEL_EXT: src_tick = s_reg.nosync ? ext_rise : (instr_tick && s_reg.ext_pend);
            default: src_tick = 1'b0;
        endcase
        // unsynchronised external edges count even in sleep
        if (sleep && !(s_reg.csel == CSEL_EXT && s_reg.nosync)) begin
            src_tick = 1'b0;
        end
        // asynchronous gate source taken without resync, keeps full resolution
        // gated mode compares the gate with its polarity
        gate_ok = !s_reg.gen || (gate_in == s_reg.gate_polarity);
        // on bit first, then the gate enable
        run = s_reg.on && gate_ok;
        ps_mask = ps_to_mask(s_reg.ps);
        // advance once the selected prescaler bits are all ones
        adv = run && src_tick && ((s_reg.psc & ps_mask) == ps_mask) && !cnt_wr;
        ovf_set = adv && (s_reg.cnt == CNT_MAX);
    end

    // Read mux; write-only clear register reads zero
    always_comb begin
        rd = '0;
        mapped = 1'b1;
        case (paddr)
            OFS_CNT_LO: rd[7:0] = s_reg.cnt[7:0];
            OFS_CNT_HI: rd[7:0] = s_reg.cnt[15:8];
            OFS_CTRL: begin
                rd[CTRL_ON_BIT] = s_reg.on;
                rd[CTRL_NOSYNC_BIT] = s_reg.nosync;
                rd[CTRL_PS_LSB +: 2] = s_reg.ps;
            end
            OFS_GATE: begin
                rd[GATE_EN_BIT] = s_reg.gen;
                rd[GATE_POL_BIT] = s_reg.gate_polarity;
                rd[GATE_VAL_BIT] = gate_in == s_reg.gate_polarity;
            end
            OFS_CSEL: rd[1:0] = s_reg.csel;
            OFS_STAT: rd[IRQ_OVF_BIT] = s_reg.ovf;
            OFS_IEN: rd[IRQ_OVF_BIT] = s_reg.ien;
            OFS_ICLR: rd = '0;
            default: mapped = 1'b0;
        endcase
    end

    // Next state
    always_comb begin
        s_next = s_reg;
        s_next.phase = 2'(s_reg.phase + 2'h1);
        // synced edges wait for the instruction tick, so at most one per cycle
        if (!s_reg.on || s_reg.nosync || cnt_wr) begin
            s_next.ext_pend = 1'b0;
        end else if (ext_rise) begin
            s_next.ext_pend = 1'b1;
        end else if (instr_tick) begin
            s_next.ext_pend = 1'b0;
        end
        // prescaler runs on every gated source tick
        if (cnt_wr) begin
            s_next.psc = 3'h0;
        end else if (run && src_tick) begin
            s_next.psc = 3'(s_reg.psc + 3'h1);
        end
        // plain increment wraps FFFF to 0000
        if (adv) begin
            s_next.cnt = 16'(s_reg.cnt + 16'h0001);
        end
        // Register writes; a count write beats a same-cycle increment
        if (wr) begin
            case (paddr)
                // byte writes go straight into the live counter
                OFS_CNT_LO: s_next.cnt[7:0] = pwdata[7:0];
                OFS_CNT_HI: s_next.cnt[15:8] = pwdata[7:0];
                OFS_CTRL: begin
                    s_next.on = pwdata[CTRL_ON_BIT];
                    // switching sync mode may gain or drop one edge
                    s_next.nosync = pwdata[CTRL_NOSYNC_BIT];
                    s_next.ps = pwdata[CTRL_PS_LSB +: 2];
                end
                OFS_GATE: begin
                    s_next.gen = pwdata[GATE_EN_BIT];
                    s_next.gate_polarity = pwdata[GATE_POL_BIT];
                end
                OFS_CSEL: s_next.csel = pwdata[1:0];
                OFS_IEN: s_next.ien = pwdata[IRQ_OVF_BIT];
                default: s_next.csel = s_next.csel;
            endcase
        end
        // overflow sticky; a new overflow wins over the clear
        if (wr && paddr == OFS_ICLR && pwdata[IRQ_OVF_BIT]) begin
            s_next.ovf = 1'b0;
        end
        if (ovf_set) begin
            s_next.ovf = 1'b1;
        end
        // Answer one cycle after setup; data sampled at the setup edge
        s_next.pready = setup;
        s_next.pslverr = setup && !mapped;
        if (setup) begin
            s_next.prdata = pwrite ? 32'h0000_0000 : rd;
        end
        // the level wakes the core; it is registered on pclk at the same edge as the flag
        s_next.irq = s_next.ovf && s_next.ien;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.cnt <= CNT_RST;
            s_reg.ps <= PS_RST;
            s_reg.csel <= CSEL_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    always_comb begin
        prdata = s_reg.prdata;
        pready = s_reg.pready;
        pslverr = s_reg.pslverr;
        irq = s_reg.irq;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence wrap_s;
        adv && (s_reg.cnt == CNT_MAX);
    endsequence

    // Setup cycle answered by ready in the next cycle
    apb_ready_a: assert property (apb_setup_s |=> (pready && !$past(pready)))
        else $error("ready not raised after setup");

    overflow_wrap_a: assert property (wrap_s |=> (s_reg.cnt == 16'h0000 && s_reg.ovf))
        else $error("wrap did not clear count and set flag");

    low_write_a: assert property (wr && paddr == OFS_CNT_LO |=>
        s_reg.cnt[7:0] == $past(pwdata[7:0]))
        else $error("low byte write not applied");

    psc_clear_a: assert property (cnt_wr |=> s_reg.psc == 3'h0)
        else $error("prescaler not cleared by count write");

    off_hold_a: assert property (!s_reg.on && !wr |=> $stable(s_reg.cnt))
        else $error("counter moved while off");

    gate_hold_a: assert property (s_reg.gen && gate_in != s_reg.gate_polarity && !wr
        |=> $stable(s_reg.cnt))
        else $error("counter moved with gate closed");

    fosc_rate_a: assert property (s_reg.on && !s_reg.gen && s_reg.csel == CSEL_FOSC
        && s_reg.ps == 2'h0 && !sleep && !wr |=> s_reg.cnt == 16'($past(s_reg.cnt) + 16'h0001))
        else $error("oscillator source not counting every clock");

    instr_rate_a: assert property (s_reg.csel == CSEL_INSTR && s_reg.phase != PHASE_LAST
        && !wr |=> $stable(s_reg.cnt))
        else $error("timer advanced off the instruction tick");

    // divide by eight leaves seven idle edges
    prescale_a: assert property (adv && s_reg.ps == 2'h3 |=>
        (!adv || s_reg.ps != 2'h3) [*7])
        else $error("advance before prescaler terminal count");

    sleep_hold_a: assert property (sleep && !(s_reg.csel == CSEL_EXT && s_reg.nosync)
        && !wr |=> $stable(s_reg.cnt))
        else $error("counter moved in sleep in synchronous mode");

    // a new overflow beats a same-cycle clear
    ovf_set_wins_a: assert property (ovf_set |=> s_reg.ovf)
        else $error("overflow lost against a clear");

    ovf_sticky_a: assert property (s_reg.ovf && !(wr && paddr == OFS_ICLR)
        |=> s_reg.ovf)
        else $error("overflow flag dropped without a clear");

    // unsynchronised rise counts at the next edge
    async_count_a: assert property (s_reg.on && !s_reg.gen && s_reg.csel == CSEL_EXT
        && s_reg.nosync && s_reg.ps == 2'h0 && ext_rise && !wr
        |=> s_reg.cnt == 16'($past(s_reg.cnt) + 16'h0001))
        else $error("unsynchronised external rise not counted");

    // synchronised edges count at most once per instruction cycle
    sync_once_a: assert property (adv && s_reg.csel == CSEL_EXT && !s_reg.nosync |=>
        (!adv || s_reg.csel != CSEL_EXT || s_reg.nosync) [*3])
        else $error("synchronised edges counted faster than instruction cycle");

    irq_level_a: assert property (irq == (s_reg.ovf && s_reg.ien))
        else $error("interrupt level disagrees with flag and enable");

endmodule

/* File: verification/gtcc_ext_src.sv */
// Behavioural source of the external count input and the gate level
`timescale 1ns/100ps
module gtcc_ext_src (
    input wire logic pclk, // Core clock
    output logic ext_in,   // External count input level
    output logic gate_in   // Gate level
);
    // Both lines start low, so the first edge seen is a rise
    initial begin
        ext_in = 1'b0;
        gate_in = 1'b0;
    end

    // Gate level changes just after an edge and then stands
    task automatic set_gate(input logic v);
        @(posedge pclk);
        gate_in <= v;
    endtask

    // One level change of the input, held for hold cycles
    task automatic step(input logic v, input int hold);
        @(posedge pclk);
        ext_in <= v;
        repeat (hold) @(posedge pclk);
    endtask

    task automatic pulses(input int n, input int hold);
        for (int i = 0; i < n; i++) begin
            step(1'b0, hold);
            step(1'b1, hold);
        end
    endtask
endmodule

/* File: verification/gtcc_core_tb.sv */
// Self-checking bench of the gated timer/counter core over APB
`timescale 1ns/100ps
module gtcc_core_tb
    import gtcc_pkg::*;
;
    typedef struct packed {
        logic [1:0] cs;
        logic [1:0] ps;
        logic [7:0] gt;
        logic lvl;
        logic on;
        logic slp;
        logic [7:0] ex;
    } gtcc_case_t;

    logic pclk, presetn, psel, penable, pwrite, sleep;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, irq, ext_in, gate_in, err_seen;
    int num_errors = 0;
    int num_checks = 0;
    gtcc_case_t c;
    // Windows are 64 edges long, a multiple of every division in use
    gtcc_case_t cases [12] = '{
        '{CSEL_FOSC, 2'h0, 8'h00, 1'b0, 1'b1, 1'b0, 8'h40},
        '{CSEL_FOSC, 2'h1, 8'h00, 1'b0, 1'b1, 1'b0, 8'h20},
        '{CSEL_FOSC, 2'h2, 8'h00, 1'b0, 1'b1, 1'b0, 8'h10},
        '{CSEL_FOSC, 2'h3, 8'h00, 1'b0, 1'b1, 1'b0, 8'h08},
        '{CSEL_INSTR, 2'h0, 8'h00, 1'b0, 1'b1, 1'b0, 8'h10},
        '{CSEL_INSTR, 2'h2, 8'h00, 1'b0, 1'b1, 1'b0, 8'h04},
        '{2'h3, 2'h0, 8'h00, 1'b0, 1'b1, 1'b0, 8'h00},
        '{CSEL_FOSC, 2'h0, 8'hC0, 1'b0, 1'b1, 1'b0, 8'h00},
        '{CSEL_FOSC, 2'h0, 8'hC0, 1'b1, 1'b1, 1'b0, 8'h40},
        '{CSEL_FOSC, 2'h0, 8'h80, 1'b0, 1'b1, 1'b0, 8'h40},
        '{CSEL_FOSC, 2'h0, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00},
        '{CSEL_FOSC, 2'h0, 8'h00, 1'b0, 1'b1, 1'b1, 8'h00}
    };
    logic [7:0] raddr [8] = '{OFS_CNT_LO, OFS_CNT_HI, OFS_CTRL, OFS_CSEL, OFS_STAT,
        OFS_IEN, OFS_ICLR, 8'h20};

    gtcc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_in(ext_in), .gate_in(gate_in), .sleep(sleep), .irq(irq));
    gtcc_ext_src src (.pclk(pclk), .ext_in(ext_in), .gate_in(gate_in));

    // Free-running 10 MHz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; read data and error are taken at the ready edge only
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sleep = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, unmapped address refused
        foreach (raddr[i]) begin
            xfer(1'b0, raddr[i], 32'h0);
            chk("reset read", rdat, 32'h0);
            chk("slave error", 32'(err_seen), 32'(raddr[i] == 8'h20));
        end
        // Source, prescale, gate and sleep table; enable window is 64 edges
        foreach (cases[i]) begin
            c = cases[i];
            xfer(1'b1, OFS_CSEL, 32'(c.cs));
            xfer(1'b1, OFS_GATE, 32'(c.gt));
            src.set_gate(c.lvl);
            sleep <= c.slp;
            xfer(1'b1, OFS_CNT_LO, 32'h0);
            xfer(1'b1, OFS_CTRL, (32'(c.on) << CTRL_ON_BIT) | (32'(c.ps) << CTRL_PS_LSB));
            repeat (61) @(posedge pclk);
            xfer(1'b1, OFS_CTRL, 32'h0);
            sleep <= 1'b0;
            xfer(1'b0, OFS_CNT_LO, 32'h0);
            chk("count", rdat, 32'(c.ex));
            xfer(1'b0, OFS_GATE, 32'h0);
            chk("gate reg", rdat, 32'(c.gt | (8'(c.lvl == c.gt[GATE_POL_BIT]) << GATE_VAL_BIT)));
        end
        // Byte writes, wrap, sticky flag, mask and clear; on for 3 edges
        xfer(1'b1, OFS_CSEL, 32'(CSEL_FOSC));
        xfer(1'b1, OFS_CNT_HI, 32'hFF);
        xfer(1'b1, OFS_CNT_LO, 32'hFE);
        xfer(1'b0, OFS_CNT_HI, 32'h0);
        chk("count high", rdat, 32'hFF);
        xfer(1'b0, OFS_CNT_LO, 32'h0);
        chk("count low", rdat, 32'hFE);
        xfer(1'b1, OFS_CTRL, 32'h1);
        xfer(1'b1, OFS_CTRL, 32'h0);
        xfer(1'b0, OFS_CNT_LO, 32'h0);
        chk("wrapped low", rdat, 32'h01);
        xfer(1'b0, OFS_CNT_HI, 32'h0);
        chk("wrapped high", rdat, 32'h00);
        xfer(1'b1, OFS_STAT, 32'h0);
        xfer(1'b0, OFS_STAT, 32'h0);
        chk("overflow flag", rdat, 32'h1);
        chk("masked irq", 32'(irq), 32'h0);
        xfer(1'b1, OFS_IEN, 32'h1);
        xfer(1'b0, OFS_IEN, 32'h0);
        chk("irq enable", rdat, 32'h1);
        chk("irq", 32'(irq), 32'h1);
        xfer(1'b1, OFS_ICLR, 32'h1);
        xfer(1'b0, OFS_STAT, 32'h0);
        chk("cleared flag", rdat, 32'h0);
        chk("cleared irq", 32'(irq), 32'h0);
        // Unsynchronised external counting in sleep; a rise with no fall is ignored
        xfer(1'b1, OFS_CSEL, 32'(CSEL_EXT));
        xfer(1'b1, OFS_CTRL, 32'h5);
        xfer(1'b1, OFS_CNT_LO, 32'h0);
        src.step(1'b1, 4);
        sleep <= 1'b1;
        src.pulses(3, 4);
        sleep <= 1'b0;
        xfer(1'b0, OFS_CNT_LO, 32'h0);
        chk("async edges", rdat, 32'h3);
        // Synchronised external counting; count write rearms the detector
        xfer(1'b1, OFS_CTRL, 32'h1);
        xfer(1'b1, OFS_CNT_LO, 32'h0);
        src.pulses(3, 6);
        repeat (10) @(posedge pclk);
        xfer(1'b0, OFS_CNT_LO, 32'h0);
        chk("sync edges", rdat, 32'h3);
        end_sim();
    end

    // Watchdog well beyond the roughly 1200 cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        end_sim();
    end
endmodule
